// [logic/asm_pkg.sv]
// Package for the async SRAM host controller: widths and timing counts
package asm_pkg;
    localparam int ADDR_W = 21;
    localparam int BYTE_ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 25;
    // Pin timing of the memory in ns
    localparam int T_CYCLE_NS = 55;
    localparam int T_PULSE_NS = 40;
    localparam int T_ACCESS_NS = 55;
    localparam int T_FLOAT_NS = 20;
    // Least times round up to whole clocks
    localparam int CYC_PULSE = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_ACCESS = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_CYCLE = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_FLOAT = (T_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 3;
    typedef enum logic [2:0] {
        ASM_IDLE = 3'b000,
        ASM_SETUP = 3'b001,
        ASM_STROBE = 3'b011,
        ASM_RECOVER = 3'b010,
        ASM_GAP = 3'b110
    } asm_state_t;
endpackage

// [logic/asm_sram_host.sv]
// Host controller that drives an async byte-lane SRAM through its pins
`timescale 1ns/1ps
module asm_sram_host
    import asm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic byte_mode,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [BYTE_ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_lanes,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    output logic [ADDR_W-1:0] address_lines,
    output logic extra_address_bit,
    output logic width_select,
    output logic primary_select_n,
    output logic secondary_select,
    output logic write_strobe_n,
    output logic output_drive_enable_n,
    output logic upper_lane_enable_n,
    output logic lower_lane_enable_n,
    input wire logic [DATA_W-1:0] data_lines_i,
    output logic [DATA_W-1:0] data_lines_o,
    output logic [DATA_W-1:0] data_lines_oe
);
    asm_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic wr_q, wr_d;
    logic [BYTE_ADDR_W-1:0] addr_q, addr_d;
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic [1:0] lanes_q, lanes_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic rsp_q, rsp_d;
    logic mode_q, mode_d;
    logic [DATA_W-1:0] sync1_q, sync2_q;

    // Read data crosses from the pins, so two flops before use
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_q <= 16'h0000;
            sync2_q <= 16'h0000;
        end else begin
            sync1_q <= data_lines_i;
            sync2_q <= sync1_q;
        end
    end

    // Width select is the inverse of byte_mode, taken in every idle cycle and held through each request
    assign req_ready = (state_q == ASM_IDLE);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        lanes_d = lanes_q;
        rdata_d = rdata_q;
        rsp_d = 1'b0;
        mode_d = mode_q;
        case (state_q)
            ASM_IDLE: begin
                mode_d = byte_mode;
                if (req_valid) begin
                    wr_d = req_write;
                    addr_d = req_addr;
                    wdata_d = req_wdata;
                    // In byte mode lanes are unused; lower lane carries data
                    lanes_d = byte_mode ? 2'b01 : req_lanes;
                    cnt_d = '0;
                    state_d = ASM_SETUP;
                end
            end
            ASM_SETUP: begin
                // Address settles one clock before the strobe opens
                cnt_d = '0;
                state_d = ASM_STROBE;
            end
            ASM_STROBE: begin
                // Writes hold the strobe for the pulse count; reads add sync delay
                if (cnt_q == CNT_W'(CYC_PULSE - 1) && wr_q) begin
                    state_d = ASM_RECOVER;
                    cnt_d = '0;
                end else if (cnt_q == CNT_W'(CYC_ACCESS + 1) && !wr_q) begin
                    rdata_d = sync2_q;
                    rsp_d = 1'b1;
                    state_d = ASM_RECOVER;
                    cnt_d = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            ASM_RECOVER: begin
                // Keep data held past strobe end, then let bus float
                cnt_d = '0;
                state_d = ASM_GAP;
            end
            ASM_GAP: begin
                // Memory output may take a while to release the bus
                if (cnt_q == CNT_W'(CYC_FLOAT - 1)) begin
                    state_d = ASM_IDLE;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            default: state_d = ASM_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ASM_IDLE;
            cnt_q <= '0;
            wr_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= 16'h0000;
            lanes_q <= 2'h0;
            rdata_q <= 16'h0000;
            rsp_q <= 1'b0;
            mode_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            lanes_q <= lanes_d;
            rdata_q <= rdata_d;
            rsp_q <= rsp_d;
            mode_q <= mode_d;
        end
    end

    // Selected from setup through recover; idle and gap leave it in standby
    function automatic logic asm_in_cycle(input asm_state_t s);
        asm_in_cycle = (s != ASM_IDLE) && (s != ASM_GAP);
    endfunction

    // Pin levels are decoded from the next state and registered, so the
    // memory never sees a decode glitch on its strobe or selects
    logic [ADDR_W-1:0] addr_pin_q, addr_pin_d;
    logic extra_pin_q, extra_pin_d;
    logic width_pin_q, width_pin_d;
    logic sel_n_q, sel_n_d;
    logic sel_q, sel_d;
    logic we_n_q, we_n_d;
    logic oe_n_q, oe_n_d;
    logic upper_n_q, upper_n_d;
    logic lower_n_q, lower_n_d;
    logic [DATA_W-1:0] drive_q, drive_d;

    always_comb begin
        width_pin_d = ~mode_d;
        // Word address uses bits 21:1 in byte mode; bit 0 goes out as extra bit
        addr_pin_d = mode_d ? addr_d[BYTE_ADDR_W-1:1] : addr_d[ADDR_W-1:0];
        extra_pin_d = mode_d ? addr_d[0] : 1'h0;
        // Deselect both ways between cycles keeps the memory in standby
        sel_n_d = ~asm_in_cycle(state_d);
        sel_d = asm_in_cycle(state_d);
        we_n_d = ~((state_d == ASM_STROBE) && wr_d);
        // Output enable stays high on writes so the pins never fight
        oe_n_d = ~(asm_in_cycle(state_d) && !wr_d);
        lower_n_d = ~(asm_in_cycle(state_d) && lanes_d[0]);
        upper_n_d = ~(asm_in_cycle(state_d) && lanes_d[1]);
        // Host drives only lanes it writes, through recover for hold time
        drive_d = (asm_in_cycle(state_d) && wr_d && (state_d != ASM_SETUP)) ?
            {{8{lanes_d[1]}}, {8{lanes_d[0]}}} : 16'h0000;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_pin_q <= '0;
            extra_pin_q <= 1'h0;
            width_pin_q <= 1'h1;
            sel_n_q <= 1'h1;
            sel_q <= 1'h0;
            we_n_q <= 1'h1;
            oe_n_q <= 1'h1;
            upper_n_q <= 1'h1;
            lower_n_q <= 1'h1;
            drive_q <= 16'h0000;
        end else begin
            addr_pin_q <= addr_pin_d;
            extra_pin_q <= extra_pin_d;
            width_pin_q <= width_pin_d;
            sel_n_q <= sel_n_d;
            sel_q <= sel_d;
            we_n_q <= we_n_d;
            oe_n_q <= oe_n_d;
            upper_n_q <= upper_n_d;
            lower_n_q <= lower_n_d;
            drive_q <= drive_d;
        end
    end

    assign rsp_valid = rsp_q;
    assign rsp_rdata = rdata_q;
    assign width_select = width_pin_q;
    assign address_lines = addr_pin_q;
    assign extra_address_bit = extra_pin_q;
    assign primary_select_n = sel_n_q;
    assign secondary_select = sel_q;
    assign write_strobe_n = we_n_q;
    assign output_drive_enable_n = oe_n_q;
    assign lower_lane_enable_n = lower_n_q;
    assign upper_lane_enable_n = upper_n_q;
    assign data_lines_o = wdata_q;
    assign data_lines_oe = drive_q;
endmodule // asm_sram_host

// [tb/asm_mem_model.sv]
// Behavioural byte-lane static memory driven from the host pins
`timescale 1ns/1ps
module asm_mem_model (
    input wire logic [22:0] key,
    input wire logic sel_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [1:0] lane_n,
    input wire logic [15:0] din,
    output logic [15:0] dout
);
    logic [15:0] mem [int];
    logic [15:0] w;
    logic rd;
    always @(posedge we_n) if (!sel_n) begin
        if (!lane_n[0]) mem[key][7:0] = din[7:0];
        if (!lane_n[1]) mem[key][15:8] = din[15:8];
    end
    always @* begin
        w = mem.exists(key) ? mem[key] : 16'hA5A5;
        rd = !sel_n && we_n && !oe_n;
        // Floated lanes show inverted data so a late sample cannot pass
        dout[7:0] = rd && !lane_n[0] ? w[7:0] : ~w[7:0];
        dout[15:8] = rd && !lane_n[1] ? w[15:8] : ~w[15:8];
    end
endmodule // asm_mem_model

// [tb/asm_sram_host_assertions.sv]
// Pin protocol checker for the async SRAM host controller
`timescale 1ns/1ps
module asm_host_chk
    import asm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic rsp_valid,
    input wire logic primary_select_n,
    input wire logic secondary_select,
    input wire logic write_strobe_n,
    input wire logic output_drive_enable_n,
    input wire logic [DATA_W-1:0] data_lines_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire sel = !primary_select_n && secondary_select;
    sequence s_wr; req_valid && req_ready && req_write; endsequence
    sequence s_pulse; !write_strobe_n [*2] ##1 write_strobe_n; endsequence
    a_write_pulse: assert property (s_wr |-> ##2 s_pulse) else $error("bad pulse");
    a_write_setup: assert property (s_wr |=> sel && write_strobe_n) else $error("bad setup");
    a_write_pins: assert property (!write_strobe_n |-> sel && output_drive_enable_n
        && data_lines_oe != 0) else $error("bad write");
    a_read_pins: assert property (!output_drive_enable_n |-> sel && write_strobe_n
        && data_lines_oe == 0) else $error("bad read");
    a_read_answer: assert property (req_valid && req_ready && !req_write |-> ##7 rsp_valid)
        else $error("late data");
    a_idle_deselect: assert property (req_ready |-> !sel) else $error("idle selected");
    a_rsp_single: assert property (rsp_valid |=> !rsp_valid) else $error("long pulse");
    a_float_gap: assert property ($rose(primary_select_n) |-> data_lines_oe == 0)
        else $error("driven at end");
endmodule // asm_host_chk
bind asm_sram_host asm_host_chk chk_u (.*);

// [tb/tb_top.sv]
// Self-checking bench for the async SRAM host controller
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rstn = 0, byte_mode = 0, req_valid = 0, req_write = 0;
    logic [21:0] req_addr = 0;
    logic [15:0] req_wdata = 0, data_lines_i, data_lines_o, data_lines_oe, rsp_rdata, mq;
    logic [1:0] req_lanes = 0;
    logic [20:0] address_lines;
    logic req_ready, rsp_valid, extra_address_bit, width_select, primary_select_n;
    logic secondary_select, write_strobe_n, output_drive_enable_n;
    logic upper_lane_enable_n, lower_lane_enable_n;
    logic [15:0] refm [int];
    int fail_count = 0, checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    asm_sram_host dut_u (.*);
    assign data_lines_i = (data_lines_oe & data_lines_o) | (~data_lines_oe & mq);
    asm_mem_model mem_u (.key({~width_select, extra_address_bit, address_lines}),
        .sel_n(primary_select_n | ~secondary_select), .we_n(write_strobe_n),
        .oe_n(output_drive_enable_n), .lane_n({upper_lane_enable_n, lower_lane_enable_n}),
        .din(data_lines_i), .dout(mq));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic op(input logic w, input logic bm, input logic [21:0] a, input logic [15:0] d,
        input logic [1:0] ln);
        int n;
        int k;
        logic [15:0] m;
        k = {bm, a};
        m = bm ? 16'h00FF : {{8{ln[1]}}, {8{ln[0]}}};
        n = 0;
        while (req_ready !== 1'b1 && n < 30) begin @(posedge clk); #1; n++; end
        {byte_mode, req_write, req_addr, req_wdata, req_lanes, req_valid} = {bm, w, a, d, ln, 1'b1};
        @(posedge clk); #1;
        req_valid = 0;
        n = 0;
        if (w) refm[k] = (refm[k] & ~m) | (d & m);
        else begin
            while (rsp_valid !== 1'b1 && n < 30) begin @(posedge clk); #1; n++; end
            chk({15'h0, rsp_valid}, 16'h0001);
            chk(rsp_rdata & m, refm[k] & m);
        end
    endtask
    initial begin
        logic [21:0] a;
        logic bm;
        void'($urandom(32'hD302181C));
        repeat (20) @(posedge clk);
        #1 rstn = 1;
        repeat (30) begin
            bm = 1'($urandom);
            a = 22'($urandom);
            if (!bm) a[21] = 0;
            op(1, bm, a, 16'($urandom), 2'h3);
            op(1, bm, a, 16'($urandom), 2'($urandom_range(3, 1)));
            op(0, bm, a, 16'h0, 2'h3);
            op(0, bm, a, 16'h0, 2'($urandom_range(3, 1)));
        end
        close_out;
    end
    always @(posedge clk) if (++cyc == 4000) begin fail_count++; close_out; end
endmodule // tb_top
